/* frs_pkg.sv */
// Purpose: Shared constants for the fault and restart sequencer.
// Assumes: pclk at 100 MHz; APB registers, one aligned 32-bit word each.
// Notes: Times are kept in their printed units; cycle counts derive from them.
package frs_pkg;
	// Clock rate
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;

	// Protection intervals in printed units
	localparam int T_OV_BLANK_MS = 20;
	localparam int T_UV_DECLARE_MS = 50;
	localparam int T_OVERLOAD_MS = 15;
	localparam int T_HICCUP_S = 1;

	// Derived cycle counts
	localparam int OV_BLANK_CYC = T_OV_BLANK_MS * CLK_KHZ;
	localparam int UV_DECLARE_CYC = T_UV_DECLARE_MS * CLK_KHZ;
	localparam int OVERLOAD_CYC = T_OVERLOAD_MS * CLK_KHZ;
	localparam int HICCUP_CYC = T_HICCUP_S * CLK_HZ;

	// Timer counter width, enough for the longest interval
	localparam int TIMER_W = 27;

	// Register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_INT_STAT = 12'h008;
	localparam logic [11:0] ADDR_INT_MASK = 12'h00C;

	// Control fields and reset value
	localparam int CTRL_LATCH_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// Event bit positions in the interrupt status and mask registers
	localparam int EV_OVERLOAD = 0;
	localparam int EV_LINE_UV = 1;
	localparam int EV_LINE_OV = 2;
	localparam int EV_HICCUP_END = 3;
	localparam int EV_LATCH_CLEAR = 4;
	localparam int EV_W = 5;
	localparam logic [EV_W-1:0] INT_MASK_RESET = 5'h00;

	// Comparator input positions in the synchroniser bank
	localparam int IN_START = 0;
	localparam int IN_MIN = 1;
	localparam int IN_RESET = 2;
	localparam int IN_TURNOFF = 3;
	localparam int IN_HYST = 4;
	localparam int IN_LINE_ON = 5;
	localparam int IN_LINE_OFF = 6;
	localparam int IN_LINE_EN = 7;
	localparam int IN_OV_UP = 8;
	localparam int IN_OV_LO = 9;
	localparam int IN_ILIM = 10;
	localparam int IN_MAXIMUM_DUTY_LIMIT = 11;
	localparam int IN_W = 12;

	// Timer slots
	localparam int TM_OV = 0;
	localparam int TM_UV = 1;
	localparam int TM_OL = 2;
	localparam int TM_HIC = 3;
	localparam int TM_N = 4;
endpackage

/* frs_timer.sv */
// Purpose: Interval counter that runs while its condition holds.
// Assumes: limit stays constant while run is high.
// Notes: Clears at once when run falls, so a broken interval starts over.
`timescale 1ns/1ps
module frs_timer #(
	parameter int W = 27
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [W-1:0] limit,
	// Result
	output logic expired
);
	logic [W-1:0] count_r;

	// Count up and saturate at the limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= '0;
		end else if (!run) begin
			count_r <= '0; // RL17
		end else if (count_r != limit) begin
			count_r <= count_r + W'(1);
		end
	end

	assign expired = run && (count_r == limit);
endmodule

/* frs_sequencer.sv */
// Purpose: Fault and restart sequencing of a fixed-frequency power controller.
// Assumes: Comparator results arrive asynchronously and are synchronised here.
// Notes: Inputs are synchronised here; edges count one cycle after the level settles.
// Notes on behaviour
// RL1: After line undervoltage clears, pulsing waits for the next rising supply start crossing.
// RL2: Line overvoltage stops pulsing after 20 ms blanking until line drops below the lower level.
// RL3: The line sense enable level is sampled at the supply minimum crossing after a supply reset.
// RL4: A low sampled line sense level disables line undervoltage and overvoltage protection.
// RL5: An overload flag held over 15 ms stops pulses and starts the 1 s recovery timer.
// RL6: In recovery with supply below minimum, the start-up source runs until the start level.
// RL7: In recovery with supply above minimum, the source waits until supply decays below minimum.
// RL8: Start crossings are ignored while the recovery timer runs.
// RL9: Each restart after a recovery hiccup begins with soft-start.
// RL10: Maximum duty limiting also runs the overload timer.
// RL11: The recovery hiccup runs whatever the line undervoltage state.
// RL12: Line undervoltage recovery during a hiccup abandons the timer and restarts at next crossing.
// RL13: In latched mode overload expiry latches off and supply cycles on turn-off hysteresis.
// RL14: The latch clears only on supply reset, line undervoltage recovery or line overvoltage.
// RL15: Line undervoltage is declared after 50 ms below the off level, and pulsing stops.
// RL16: After any fault or line undervoltage the soft-start ramp is forced to zero.
// RL17: Each interval counter clears whenever its condition drops.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module frs_sequencer
	import frs_pkg::*;
#(
	parameter int OV_BLANK_CYCLES = OV_BLANK_CYC,
	parameter int UV_DECLARE_CYCLES = UV_DECLARE_CYC,
	parameter int OVERLOAD_CYCLES = OVERLOAD_CYC,
	parameter int HICCUP_CYCLES = HICCUP_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Supply comparators
	input wire logic supply_above_start,
	input wire logic supply_above_minimum,
	input wire logic supply_above_reset,
	input wire logic supply_above_turnoff,
	input wire logic supply_above_turnoff_hyst,
	// Line sense comparators
	input wire logic line_above_on,
	input wire logic line_below_off,
	input wire logic line_above_enable,
	input wire logic line_above_ov_upper,
	input wire logic line_above_ov_lower,
	// Overload sources
	input wire logic peak_current_limit,
	input wire logic maximum_duty_limit,
	// Power stage control
	output logic drive_enable,
	output logic startup_current_source,
	output logic soft_start_discharge,
	output logic soft_start_begin,
	// Interrupt
	output logic irq
);
	typedef enum logic [1:0] {
		ST_OFF,
		ST_RUN,
		ST_HICCUP,
		ST_LATCHED
	} frs_state_e;

	frs_state_e state_r;
	frs_state_e state_nxt;

	logic [IN_W-1:0] raw;
	logic [IN_W-1:0] s1_r;
	logic [IN_W-1:0] s2_r;
	logic [IN_W-1:0] s3_r;
	logic [IN_W-1:0] in_r;
	logic [IN_W-1:0] prev_r;

	logic [1:0] ctrl_r;
	logic [EV_W-1:0] int_stat_r;
	logic [EV_W-1:0] int_stat_nxt;
	logic [EV_W-1:0] int_mask_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_mux;

	logic sample_armed_r;
	logic line_en_r;
	logic line_uv_r;
	logic line_ov_r;
	logic src_r;
	logic src_nxt;
	logic start_pulse_r;

	logic [TM_N-1:0] tm_run;
	logic [TM_N-1:0] tm_exp;
	logic [TIMER_W-1:0] tm_limit [TM_N];

	// Comparator bank in package order
	assign raw = {maximum_duty_limit, peak_current_limit, line_above_ov_lower,
		line_above_ov_upper, line_above_enable, line_below_off, line_above_on,
		supply_above_turnoff_hyst, supply_above_turnoff, supply_above_reset,
		supply_above_minimum, supply_above_start};

	// Three-stage synchroniser; a change is taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < IN_W; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
					s3_r[gi] <= 1'b0;
					in_r[gi] <= 1'b0;
					prev_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= raw[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						in_r[gi] <= s3_r[gi];
					end
					prev_r[gi] <= in_r[gi];
				end
			end
		end
	endgenerate

	// Decoded comparator levels and edges
	wire start_rise = in_r[IN_START] && !prev_r[IN_START];
	wire min_rise = in_r[IN_MIN] && !prev_r[IN_MIN];
	wire below_min = !in_r[IN_MIN];
	wire above_start = in_r[IN_START];
	wire supply_reset = !in_r[IN_RESET];
	wire overload_flag = in_r[IN_ILIM] || in_r[IN_MAXIMUM_DUTY_LIMIT]; // RL10

	// Line protections act only when the sense was found enabled
	wire uv_cond = line_en_r && in_r[IN_LINE_OFF] && !line_uv_r; // RL4
	wire ov_cond = line_en_r && in_r[IN_OV_UP] && !line_ov_r; // RL4
	wire uv_declare = tm_exp[TM_UV]; // RL15
	wire ov_declare = tm_exp[TM_OV]; // RL2
	wire uv_recover = line_uv_r && in_r[IN_LINE_ON];
	wire ov_release = line_ov_r && !in_r[IN_OV_LO];
	wire line_fault = line_uv_r || line_ov_r;

	// Configuration fields
	wire latch_mode = ctrl_r[CTRL_LATCH_BIT];
	wire run_allow = ctrl_r[CTRL_RUN_BIT];

	// Timer conditions; overload counting only while pulses run
	assign tm_run[TM_OV] = ov_cond;
	assign tm_run[TM_UV] = uv_cond;
	assign tm_run[TM_OL] = (state_r == ST_RUN) && overload_flag; // RL5
	assign tm_run[TM_HIC] = (state_r == ST_HICCUP);
	assign tm_limit[TM_OV] = TIMER_W'(OV_BLANK_CYCLES);
	assign tm_limit[TM_UV] = TIMER_W'(UV_DECLARE_CYCLES);
	assign tm_limit[TM_OL] = TIMER_W'(OVERLOAD_CYCLES);
	assign tm_limit[TM_HIC] = TIMER_W'(HICCUP_CYCLES);

	// Interval timers, one per protection interval
	generate
		for (gi = 0; gi < TM_N; gi++) begin : g_tmr
			frs_timer #(
				.W(TIMER_W)
			) u_timer (
				.pclk(pclk),
				.presetn(presetn),
				.run(tm_run[gi]),
				.limit(tm_limit[gi]),
				.expired(tm_exp[gi])
			);
		end
	endgenerate

	wire overload_trip = tm_exp[TM_OL];
	wire hiccup_end = tm_exp[TM_HIC];
	wire latch_release = supply_reset || uv_recover || ov_declare; // RL14

	// Sampling of the line sense enable level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_armed_r <= 1'b1;
			line_en_r <= 1'b0;
		end else if (supply_reset) begin
			sample_armed_r <= 1'b1; // RL3
		end else if (sample_armed_r && min_rise) begin
			sample_armed_r <= 1'b0;
			line_en_r <= in_r[IN_LINE_EN]; // RL3
		end
	end

	// Line undervoltage and overvoltage flags; disabled sense clears both
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_uv_r <= 1'b0;
			line_ov_r <= 1'b0;
		end else if (!line_en_r) begin
			line_uv_r <= 1'b0; // RL4
			line_ov_r <= 1'b0; // RL4
		end else begin
			if (uv_declare) begin
				line_uv_r <= 1'b1; // RL15
			end else if (uv_recover) begin
				line_uv_r <= 1'b0;
			end
			if (ov_declare) begin
				line_ov_r <= 1'b1; // RL2
			end else if (ov_release) begin
				line_ov_r <= 1'b0; // RL2
			end
		end
	end

	// Sequencer; a supply reset overrides every state
	always_comb begin
		state_nxt = state_r;
		if (supply_reset) begin
			state_nxt = ST_OFF; // RL14
		end else begin
			unique case (state_r)
				ST_OFF: begin
					// Only a fresh crossing starts, never a standing level
					if (start_rise && !line_fault && run_allow) begin
						state_nxt = ST_RUN; // RL1
					end
				end
				ST_RUN: begin
					if (line_fault || !run_allow) begin
						state_nxt = ST_OFF; // RL15
					end else if (overload_trip && latch_mode) begin
						state_nxt = ST_LATCHED; // RL13
					end else if (overload_trip) begin
						state_nxt = ST_HICCUP; // RL5
					end
				end
				ST_HICCUP: begin // RL11
					// Start crossings are not looked at here, nor is a standing line fault
					if (uv_recover) begin
						state_nxt = ST_OFF; // RL12
					end else if (hiccup_end) begin
						state_nxt = ST_OFF; // RL8
					end
				end
				ST_LATCHED: begin
					if (latch_release) begin
						state_nxt = ST_OFF; // RL14
					end
				end
			endcase
		end
	end

	// Start-up source: hysteretic on supply levels, band chosen by state
	always_comb begin
		src_nxt = src_r;
		unique case (state_r)
			ST_LATCHED: begin
				if (!in_r[IN_TURNOFF]) begin
					src_nxt = 1'b1; // RL13
				end else if (in_r[IN_HYST]) begin
					src_nxt = 1'b0; // RL13
				end
			end
			ST_RUN: begin
				src_nxt = 1'b0;
			end
			default: begin
				if (below_min) begin
					src_nxt = 1'b1; // RL6
				end else if (above_start) begin
					src_nxt = 1'b0; // RL7
				end
			end
		endcase
	end

	// Sequencer state, source and soft-start pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_OFF;
			src_r <= 1'b0;
			start_pulse_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			src_r <= src_nxt;
			start_pulse_r <= (state_nxt == ST_RUN) && (state_r != ST_RUN); // RL9
		end
	end

	// Power stage outputs; the ramp is held at zero whenever pulses are off
	assign drive_enable = (state_r == ST_RUN) && !line_fault;
	assign soft_start_discharge = !drive_enable; // RL16
	assign soft_start_begin = start_pulse_r; // RL9
	assign startup_current_source = src_r;

	// APB decode; zero-wait slave, read data registered in the setup cycle
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_ctrl = (paddr == ADDR_CTRL);
	wire hit_status = (paddr == ADDR_STATUS);
	wire hit_stat = (paddr == ADDR_INT_STAT);
	wire hit_mask = (paddr == ADDR_INT_MASK);
	wire hit = hit_ctrl || hit_status || hit_stat || hit_mask;
	wire wr_ctrl = access && pwrite && hit_ctrl;
	wire wr_mask = access && pwrite && hit_mask;
	wire rd_clear = access && !pwrite && hit_stat;
	assign pready = 1'b1;
	assign pslverr = access && !hit;

	// Status word shows the sequencer's own state
	wire [31:0] status_word = {20'h00000, in_r[IN_MIN], in_r[IN_START], src_r, line_en_r,
		line_ov_r, line_uv_r, drive_enable, (state_r == ST_LATCHED),
		(state_r == ST_HICCUP), (state_r == ST_RUN), 2'h0};

	// Read selection
	assign rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
		hit_status ? status_word :
		hit_stat ? {27'h0, int_stat_r} :
		hit_mask ? {27'h0, int_mask_r} : 32'h00000000;

	// Events; a read clears only the bits it reported, so an event landing between
	// setup and access is not lost, and a new event wins over a clear
	wire [EV_W-1:0] events = {(state_r == ST_LATCHED) && (state_nxt == ST_OFF),
		(state_r == ST_HICCUP) && (state_nxt == ST_OFF),
		ov_declare, uv_declare, overload_trip};
	wire [EV_W-1:0] clr_bits = rd_clear ? prdata_r[EV_W-1:0] : '0;
	assign int_stat_nxt = (int_stat_r & ~clr_bits) | events;

	// Register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RESET;
			int_mask_r <= INT_MASK_RESET;
			int_stat_r <= '0;
			prdata_r <= 32'h00000000;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= pwdata[1:0];
			end
			if (wr_mask) begin
				int_mask_r <= pwdata[EV_W-1:0];
			end
			int_stat_r <= int_stat_nxt;
			if (setup) begin
				prdata_r <= rd_mux;
			end
		end
	end

	assign prdata = prdata_r;
	assign irq = |(int_stat_r & int_mask_r);
endmodule

/* frs_sequencer_monitor.sv */
// Purpose: Port-level checks on the fault and restart sequencer.
// Assumes: Comparator inputs pass a four-edge synchroniser before use.
// Notes: Margins of a few cycles cover synchroniser latency.
`timescale 1ns/1ps
module frs_sequencer_monitor #(
	parameter int OVERLOAD_CYCLES = 15
) (
	// Clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Comparators
	input wire logic supply_above_start,
	input wire logic supply_above_reset,
	input wire logic peak_current_limit,
	input wire logic maximum_duty_limit,
	// Power stage
	input wire logic drive_enable,
	input wire logic startup_current_source,
	input wire logic soft_start_discharge,
	input wire logic soft_start_begin
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Overload run length, saturating so it never wraps back below the limit
	int ol_r;
	int ol_nxt;
	wire ol_flag = peak_current_limit | maximum_duty_limit;
	wire unmapped = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C});
	// A run may only begin while pulses are on; a flag standing from before a start is not counted
	assign ol_nxt = (!ol_flag || (ol_r == 0 && !drive_enable)) ? 0 :
		(ol_r >= OVERLOAD_CYCLES + 9) ? ol_r : ol_r + 1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ol_r <= 0;
		else ol_r <= ol_nxt;
	end
	sequence s_begin_pulse;
		soft_start_begin ##1 !soft_start_begin;
	endsequence
	sequence s_supply_reset;
		!supply_above_reset [*7];
	endsequence
	AST_PREADY: assert property (pready) else $error("pready low");
	AST_SLVERR: assert property (pslverr == (psel && penable && unmapped))
		else $error("pslverr wrong");
	AST_BEGIN_ON_RUN: assert property ($rose(drive_enable) |-> s_begin_pulse)
		else $error("no soft-start pulse at run entry");
	AST_BEGIN_IN_RUN: assert property (soft_start_begin |-> drive_enable)
		else $error("soft-start pulse outside run");
	AST_DISCHARGE: assert property (soft_start_discharge == !drive_enable)
		else $error("soft-start ramp not held at zero while stopped");
	AST_SOURCE_RUN: assert property (drive_enable && $past(drive_enable) |-> !startup_current_source)
		else $error("start-up source on while running");
	AST_START_CAUSE: assert property ($rose(drive_enable) |-> $past(supply_above_start, 3))
		else $error("run began without start crossing");
	AST_SUPPLY_RESET: assert property (s_supply_reset |-> !drive_enable)
		else $error("supply reset did not stop pulses");
	AST_OVERLOAD: assert property (ol_r >= OVERLOAD_CYCLES + 8 |-> !drive_enable)
		else $error("overload did not stop pulses");
endmodule
bind frs_sequencer frs_sequencer_monitor #(.OVERLOAD_CYCLES(OVERLOAD_CYCLES)) frs_sequencer_monitor_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .supply_above_start(supply_above_start),
	.supply_above_reset(supply_above_reset), .peak_current_limit(peak_current_limit),
	.maximum_duty_limit(maximum_duty_limit), .drive_enable(drive_enable),
	.startup_current_source(startup_current_source),
	.soft_start_discharge(soft_start_discharge), .soft_start_begin(soft_start_begin));

/* fault_restart_sequencer_bench.sv */
// Purpose: Self-checking bench for the fault and restart sequencer.
// Assumes: Short interval parameters 20, 50, 15 and 100 cycles.
// Notes: Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
module fault_restart_sequencer_bench;
	import frs_pkg::*;
	// Bench signals, all inputs valued at time zero
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, err, de, src, ssd, ssb, irq;
	logic st = 1'b0, mn = 1'b0, rs = 1'b1, to = 1'b1, hy = 1'b1;
	logic lon = 1'b1, loff = 1'b0, len = 1'b1, ovu = 1'b0, ovl = 1'b0, pk = 1'b0, md = 1'b0;
	int errors = 0, n_checks = 0, cnt, i;
	// Register rows: write flag, address, data, expected read, expected error
	logic rw[9] = '{0, 0, 0, 1, 0, 0, 1, 1, 0};
	logic [11:0] ra[9] = '{12'h000, 12'h00C, 12'h008, 12'h00C, 12'h00C, 12'h010, 12'h014,
		12'h008, 12'h008};
	logic [31:0] rd[9] = '{32'h2, 32'h0, 32'h0, 32'h1F, 32'h1F, 32'h0, 32'h5, 32'hFF, 32'h0};
	logic re[9] = '{0, 0, 0, 0, 0, 1, 1, 0, 0};
	frs_sequencer #(.OV_BLANK_CYCLES(20), .UV_DECLARE_CYCLES(50), .OVERLOAD_CYCLES(15),
		.HICCUP_CYCLES(100)) frs_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(err), .supply_above_start(st), .supply_above_minimum(mn),
		.supply_above_reset(rs), .supply_above_turnoff(to), .supply_above_turnoff_hyst(hy),
		.line_above_on(lon), .line_below_off(loff), .line_above_enable(len),
		.line_above_ov_upper(ovu), .line_above_ov_lower(ovl), .peak_current_limit(pk),
		.maximum_duty_limit(md), .drive_enable(de), .startup_current_source(src),
		.soft_start_discharge(ssd), .soft_start_begin(ssb), .irq(irq));
	// Clock at 100 MHz
	always #5 pclk = ~pclk;
	task tick(int n);
		repeat (n) @(posedge pclk);
	endtask
	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		cnt = err;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Bounded wait for the drive level
	task waitd(logic v);
		cnt = 0;
		while (de !== v && cnt < 200) begin
			@(posedge pclk);
			cnt++;
		end
	endtask
	// Fresh rising start crossing, then the expected drive level
	task tryst(logic e);
		st <= 1'b0;
		tick(8);
		st <= 1'b1;
		cnt = 0;
		repeat (20) begin
			@(posedge pclk);
			cnt += ssb;
		end
		chk("drive", de, e);
		chk("begin", cnt, e);
		chk("discharge", ssd, !e);
	endtask
	task results;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Watchdog sized well above the fewer than a thousand cycles of the sequence
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		results();
	end
	initial begin
		tick(3);
		chk("reset", {de, ssd, ssb, irq, pready, err}, 6'b010010);
		presetn <= 1'b1;
		for (i = 0; i < 9; i++) begin
			apb(rw[i], ra[i], rd[i]);
			if (!rw[i]) chk("read", r, rd[i]);
			chk("slverr", cnt, re[i]);
		end
		tick(8);
		chk("source", src, 1'b1);
		mn <= 1'b1;
		tick(8);
		tryst(1'b1);
		chk("source", src, 1'b0);
		// Maximum duty held: trip, hiccup, restart
		md <= 1'b1;
		waitd(1'b0);
		chk("ol_time", cnt >= 15 && cnt <= 30, 1);
		md <= 1'b0;
		tick(1);
		chk("irq", irq, 1'b1);
		tick(50);
		chk("drive", de, 1'b0);
		chk("source", src, 1'b0);
		tryst(1'b0);
		mn <= 1'b0;
		tick(8);
		chk("source", src, 1'b1);
		tick(60);
		apb(0, ADDR_INT_STAT, 0);
		chk("int", r, 32'h9);
		tick(1);
		chk("irq", irq, 1'b0);
		mn <= 1'b1;
		tryst(1'b1);
		// Latched option with the interrupt masked
		apb(1, ADDR_CTRL, 32'h3);
		apb(1, ADDR_INT_MASK, 32'h0);
		pk <= 1'b1;
		waitd(1'b0);
		pk <= 1'b0;
		apb(0, ADDR_STATUS, 0);
		chk("latched", {r[4], irq}, 2'b10);
		to <= 1'b0;
		hy <= 1'b0;
		tick(8);
		chk("source", src, 1'b1);
		to <= 1'b1;
		hy <= 1'b1;
		tick(8);
		chk("source", src, 1'b0);
		tryst(1'b0);
		apb(1, ADDR_INT_MASK, 32'h1F);
		tick(1);
		chk("irq", irq, 1'b1);
		rs <= 1'b0;
		mn <= 1'b0;
		tick(10);
		rs <= 1'b1;
		tick(4);
		mn <= 1'b1;
		apb(0, ADDR_INT_STAT, 0);
		chk("int", r, 32'h11);
		apb(1, ADDR_CTRL, 32'h2);
		tryst(1'b1);
		// Line undervoltage, then recovery waits for a crossing
		loff <= 1'b1;
		lon <= 1'b0;
		waitd(1'b0);
		chk("uv_time", cnt >= 50 && cnt <= 70, 1);
		loff <= 1'b0;
		lon <= 1'b1;
		tick(20);
		chk("drive", de, 1'b0);
		tryst(1'b1);
		// Hiccup runs on through a line fault, and line recovery cuts it short
		md <= 1'b1;
		waitd(1'b0);
		md <= 1'b0;
		loff <= 1'b1;
		lon <= 1'b0;
		tick(60);
		apb(0, ADDR_STATUS, 0);
		chk("hiccup_uv", {r[6], r[3]}, 2'b11);
		loff <= 1'b0;
		lon <= 1'b1;
		tick(8);
		apb(0, ADDR_STATUS, 0);
		chk("hiccup_cut", {r[6], r[3]}, 2'b00);
		tryst(1'b1);
		// Line overvoltage with blanking and lower release level
		ovu <= 1'b1;
		ovl <= 1'b1;
		waitd(1'b0);
		chk("ov_time", cnt >= 20 && cnt <= 35, 1);
		ovu <= 1'b0;
		tryst(1'b0);
		ovl <= 1'b0;
		tryst(1'b1);
		// Line sense low at the minimum crossing disables its protections
		rs <= 1'b0;
		mn <= 1'b0;
		len <= 1'b0;
		tick(10);
		rs <= 1'b1;
		tick(5);
		mn <= 1'b1;
		tick(8);
		tryst(1'b1);
		loff <= 1'b1;
		lon <= 1'b0;
		ovu <= 1'b1;
		ovl <= 1'b1;
		tick(80);
		chk("drive", de, 1'b1);
		apb(0, ADDR_STATUS, 0);
		chk("line_en", r[8], 1'b0);
		results();
	end
endmodule
